// *** video_ref_cfg.svh ***
// Constants for the video input and reference control block
`ifndef VIDEO_REF_CFG_SVH
`define VIDEO_REF_CFG_SVH

// ----------------------------------------
// Widths and buffering
// ----------------------------------------
`define VRC_DATA_W      10
`define VRC_FIFO_DEPTH  32
`define VRC_SYNC_W      36

// ----------------------------------------
// Raster sizes per standard
// ----------------------------------------
`define VRC_SPL_525     12'h6B4
`define VRC_SPL_625     12'h6C0
`define VRC_LPF_525     10'h20D
`define VRC_LPF_625     10'h271

// ----------------------------------------
// Fill words, 4:2:2 order Cb Y Cr Y
// ----------------------------------------
`define VRC_BLACK_Y     10'h040
`define VRC_BLACK_C     10'h200
`define VRC_BLUE_Y      10'h0A4
`define VRC_BLUE_CB     10'h3C0
`define VRC_BLUE_CR     10'h1D8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define VRC_RST_H_PHASE 12'h000
`define VRC_RST_V_PHASE 10'h000

`endif

// *** video_ref_pkg.sv ***
// Types for the video input and reference control block
package video_ref_pkg;
  typedef enum logic {primary_input_choice, backup_input_choice} input_choice_e;
  typedef enum logic [1:0] {std_auto, std_525, std_625} std_mode_e;
  typedef enum logic [1:0] {loss_black, loss_blue, loss_pass} loss_act_e;
  typedef enum logic {ref_external, ref_video} ref_choice_e;
  typedef enum logic [1:0] {
    card_reference_connector_choice, frame_ref2_choice, frame_ref1_choice
  } ext_ref_e;
  typedef enum logic [1:0] {lock_ext, lock_input, lock_free} lock_src_e;
endpackage

// *** timing_if.sv ***
// Raster settings and counters shared by control and timing generator
`timescale 1ns/100ps
`default_nettype none
interface timing_if;
  logic [11:0] h_total;
  logic [11:0] h_off;
  logic [11:0] h_pos;
  logic [9:0]  v_total;
  logic [9:0]  v_off;
  logic [9:0]  v_pos;
  logic        lock_pulse;
  logic        frame_start;
  modport ctrl (output h_total, h_off, v_total, v_off, lock_pulse,
                input h_pos, v_pos, frame_start);
  modport gen  (input h_total, h_off, v_total, v_off, lock_pulse,
                output h_pos, v_pos, frame_start);
endinterface // timing_if
`default_nettype wire

// *** sample_fifo.sv ***
// Sample FIFO with registered read data
`timescale 1ns/100ps
`default_nettype none
module sample_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Write side
  input  wire logic         wr_valid,
  output logic              wr_ready,
  input  wire logic [W-1:0] wr_data,
  // Read side
  output logic              rd_valid,
  input  wire logic         rd_ready,
  output logic [W-1:0]      rd_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wptr_r;
  logic [AW:0]  rptr_r;
  logic         empty;
  logic         pop;
  logic         push;

  assign empty    = (wptr_r == rptr_r);
  assign wr_ready = !((wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]));
  assign push     = wr_valid && wr_ready;
  assign pop      = !empty && (!rd_valid || rd_ready);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wptr_r[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else if (pop) begin
      rd_valid <= 1'b1;
      rd_data  <= mem[rptr_r[AW-1:0]];
    end else if (rd_ready) begin
      rd_valid <= 1'b0;
    end
  end
endmodule // sample_fifo
`default_nettype wire

// *** phase_timing_gen.sv ***
// Output raster counters with phase offset to the lock pulse
`timescale 1ns/100ps
`default_nettype none
module phase_timing_gen (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Raster settings and counters
  timing_if.gen    tif
);
  logic h_end;

  assign h_end = (tif.h_pos >= tif.h_total - 12'h001);

  // Reference edge lands at total-offset, so zero comes offset later
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tif.h_pos <= 12'h000;
      tif.v_pos <= 10'h000;
    end else if (tif.lock_pulse) begin
      tif.h_pos <= (tif.h_off == 12'h000) ? 12'h000 : tif.h_total - tif.h_off;
      tif.v_pos <= (tif.v_off == 10'h000) ? 10'h000 : tif.v_total - tif.v_off;
    end else if (h_end) begin
      tif.h_pos <= 12'h000;
      tif.v_pos <= (tif.v_pos >= tif.v_total - 10'h001) ? 10'h000
                                                         : tif.v_pos + 10'h001;
    end else begin
      tif.h_pos <= tif.h_pos + 12'h001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tif.frame_start <= 1'b0;
    end else begin
      tif.frame_start <= h_end && (tif.v_pos >= tif.v_total - 10'h001);
    end
  end

  AST_H_PHASE: assert property (@(posedge sys_clk) disable iff (rst)
    tif.lock_pulse && tif.h_off != 12'h000 && $stable(tif.h_total)
    |=> tif.h_pos == tif.h_total - $past(tif.h_off))
    else $error("H counter not placed at offset after lock");
  AST_V_PHASE: assert property (@(posedge sys_clk) disable iff (rst)
    tif.lock_pulse && tif.v_off != 10'h000 && $stable(tif.v_total)
    |=> tif.v_pos == tif.v_total - $past(tif.v_off))
    else $error("V counter not placed at offset after lock");
endmodule // phase_timing_gen
`default_nettype wire

// *** video_input_reference_control.sv ***
// Program input selection, loss handling, reference lock and phase
`timescale 1ns/100ps
`default_nettype none
`include "video_ref_cfg.svh"
module video_input_reference_control (
  // Clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  // Primary and backup serial inputs, deserialised
  input  wire logic [9:0]                   pri_data,
  input  wire logic                         pri_valid,
  input  wire logic                         pri_present,
  input  wire logic [9:0]                   bak_data,
  input  wire logic                         bak_valid,
  input  wire logic                         bak_present,
  output logic                              video_ready,
  // Standard detector of the selected input
  input  wire logic                         det_std_625,
  input  wire logic                         det_std_valid,
  input  wire logic                         in_frame_sync,
  // Genlock sources: bit 0 card, 1 frame 2, 2 frame 1
  input  wire logic [2:0]                   ref_present,
  input  wire logic [2:0]                   ref_std_625,
  input  wire logic [2:0]                   ref_sync,
  // Settings
  input  wire logic                         cfg_load,
  input  wire video_ref_pkg::input_choice_e cfg_input_choice,
  input  wire video_ref_pkg::std_mode_e     cfg_std_mode,
  input  wire video_ref_pkg::loss_act_e     cfg_input_loss_action,
  input  wire video_ref_pkg::ref_choice_e   cfg_ref_choice,
  input  wire video_ref_pkg::ext_ref_e      cfg_ext_ref,
  input  wire logic [11:0]                  cfg_h_phase,
  input  wire logic [9:0]                   cfg_v_phase,
  // Program output
  output logic [9:0]                        out_data,
  output logic                              out_valid,
  input  wire logic                         out_ready,
  // Status
  output video_ref_pkg::lock_src_e          lock_src_r,
  output logic                              std_625_r,
  output logic                              input_ok_r,
  output logic [11:0]                       h_phase_r,
  output logic [9:0]                        v_phase_r,
  output logic [11:0]                       h_pos,
  output logic [9:0]                        v_pos,
  output logic                              frame_start
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [1:0] ext_idx(input video_ref_pkg::ext_ref_e s);
    case (s)
      video_ref_pkg::frame_ref2_choice: ext_idx = 2'h1;
      video_ref_pkg::frame_ref1_choice: ext_idx = 2'h2;
      default:                          ext_idx = 2'h0;
    endcase
  endfunction

  function automatic logic [11:0] clamp(input logic [11:0] v, input logic [11:0] m);
    clamp = (v > m) ? m : v;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [`VRC_SYNC_W-1:0] meta_r;
  logic [`VRC_SYNC_W-1:0] sync_r;
  logic [9:0]             pri_data_s;
  logic                   pri_valid_s;
  logic                   pri_present_s;
  logic [9:0]             bak_data_s;
  logic                   bak_valid_s;
  logic                   bak_present_s;
  logic                   det_625_s;
  logic                   det_valid_s;
  logic [2:0]             ref_present_s;
  logic [2:0]             ref_std_s;
  logic [2:0]             ref_sync_s;
  logic                   in_sync_s;
  logic [2:0]             ref_sync_d_r;
  logic                   in_sync_d_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= {pri_valid, pri_data, pri_present, bak_valid, bak_data,
                 bak_present, det_std_625, det_std_valid, ref_present,
                 ref_std_625, ref_sync, in_frame_sync};
      sync_r <= meta_r;
    end
  end

  assign {pri_valid_s, pri_data_s, pri_present_s, bak_valid_s, bak_data_s,
          bak_present_s, det_625_s, det_valid_s, ref_present_s,
          ref_std_s, ref_sync_s, in_sync_s} = sync_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ref_sync_d_r <= 3'h0;
      in_sync_d_r  <= 1'b0;
    end else begin
      ref_sync_d_r <= ref_sync_s;
      in_sync_d_r  <= in_sync_s;
    end
  end

  // ----------------------------------------
  // Settings
  // ----------------------------------------
  video_ref_pkg::input_choice_e choice_r;
  video_ref_pkg::std_mode_e     std_mode_r;
  video_ref_pkg::loss_act_e     loss_r;
  video_ref_pkg::ref_choice_e   ref_choice_r;
  video_ref_pkg::ext_ref_e      ext_ref_r;
  logic [11:0]                  h_req_r;
  logic [9:0]                   v_req_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      choice_r     <= video_ref_pkg::primary_input_choice;
      std_mode_r   <= video_ref_pkg::std_auto;
      loss_r       <= video_ref_pkg::loss_black;
      ref_choice_r <= video_ref_pkg::ref_external;
      ext_ref_r    <= video_ref_pkg::card_reference_connector_choice;
      h_req_r      <= `VRC_RST_H_PHASE;
      v_req_r      <= `VRC_RST_V_PHASE;
    end else if (cfg_load) begin
      choice_r     <= cfg_input_choice;
      std_mode_r   <= cfg_std_mode;
      loss_r       <= cfg_input_loss_action;
      ref_choice_r <= cfg_ref_choice;
      ext_ref_r    <= cfg_ext_ref;
      h_req_r      <= cfg_h_phase;
      v_req_r      <= cfg_v_phase;
    end
  end

  // ----------------------------------------
  // Input selection and standard
  // ----------------------------------------
  logic       is_625;
  logic       accepted;
  logic       input_ok;
  logic       sel_present;
  logic       sel_valid;
  logic [9:0] sel_data;
  logic [11:0] h_total;
  logic [9:0]  v_total;

  always_comb begin
    if (choice_r == video_ref_pkg::backup_input_choice) begin
      sel_data    = bak_data_s;
      sel_valid   = bak_valid_s;
      sel_present = bak_present_s;
    end else begin
      sel_data    = pri_data_s;
      sel_valid   = pri_valid_s;
      sel_present = pri_present_s;
    end
  end

  always_comb begin
    case (std_mode_r)
      video_ref_pkg::std_525: begin
        is_625   = 1'b0;
        accepted = det_valid_s && !det_625_s;
      end
      video_ref_pkg::std_625: begin
        is_625   = 1'b1;
        accepted = det_valid_s && det_625_s;
      end
      default: begin
        is_625   = det_625_s;
        accepted = det_valid_s;
      end
    endcase
  end

  assign input_ok = sel_present && accepted;
  assign h_total  = is_625 ? `VRC_SPL_625 : `VRC_SPL_525;
  assign v_total  = is_625 ? `VRC_LPF_625 : `VRC_LPF_525;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      std_625_r  <= 1'b0;
      input_ok_r <= 1'b0;
    end else begin
      std_625_r  <= is_625;
      input_ok_r <= input_ok;
    end
  end

  // ----------------------------------------
  // Phase offsets
  // ----------------------------------------
  // Clamped every cycle, so a standard change pulls them in on the next cycle, with no reload
  logic [11:0] v_clamp;

  assign v_clamp = clamp({2'h0, v_req_r}, {2'h0, v_total});

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      h_phase_r <= `VRC_RST_H_PHASE;
      v_phase_r <= `VRC_RST_V_PHASE;
    end else begin
      h_phase_r <= clamp(h_req_r, h_total);
      v_phase_r <= v_clamp[9:0];
    end
  end

  // ----------------------------------------
  // Reference selection
  // ----------------------------------------
  logic [1:0] ext_i;
  logic       ext_ok;
  video_ref_pkg::lock_src_e lock_nxt;

  assign ext_i  = ext_idx(ext_ref_r);
  assign ext_ok = ref_present_s[ext_i] && (ref_std_s[ext_i] == is_625);

  // Correct lock to an external source also needs the source to
  // hold its video clock locked to it; nothing here can repair that.
  always_comb begin
    if (ref_choice_r == video_ref_pkg::ref_external && ext_ok) begin
      lock_nxt = video_ref_pkg::lock_ext;
    end else if (input_ok) begin
      lock_nxt = video_ref_pkg::lock_input;
    end else begin
      lock_nxt = video_ref_pkg::lock_free;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lock_src_r <= video_ref_pkg::lock_free;
    end else begin
      lock_src_r <= lock_nxt;
    end
  end

  // ----------------------------------------
  // Raster timing
  // ----------------------------------------
  timing_if tif ();
  logic     lock_pulse;

  always_comb begin
    case (lock_src_r)
      video_ref_pkg::lock_ext:   lock_pulse = ref_sync_s[ext_i] && !ref_sync_d_r[ext_i];
      video_ref_pkg::lock_input: lock_pulse = in_sync_s && !in_sync_d_r;
      default:                   lock_pulse = 1'b0;
    endcase
  end

  assign tif.h_total    = h_total;
  assign tif.v_total    = v_total;
  assign tif.h_off      = h_phase_r;
  assign tif.v_off      = v_phase_r;
  assign tif.lock_pulse = lock_pulse;
  assign h_pos          = tif.h_pos;
  assign v_pos          = tif.v_pos;
  assign frame_start    = tif.frame_start;

  phase_timing_gen u_timing (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tif     (tif.gen)
  );

  // ----------------------------------------
  // Output data path
  // ----------------------------------------
  logic [9:0] fill_word;
  logic [9:0] wr_data;
  logic       wr_valid;
  logic       wr_ready;
  logic       pass_thru;

  always_comb begin
    if (loss_r == video_ref_pkg::loss_blue) begin
      case (h_pos[1:0])
        2'h0:    fill_word = `VRC_BLUE_CB;
        2'h2:    fill_word = `VRC_BLUE_CR;
        default: fill_word = `VRC_BLUE_Y;
      endcase
    end else begin
      fill_word = h_pos[0] ? `VRC_BLACK_Y : `VRC_BLACK_C;
    end
  end

  // Pass mode forwards raw samples, coherent or not
  assign pass_thru   = input_ok || (loss_r == video_ref_pkg::loss_pass);
  assign wr_valid    = pass_thru ? sel_valid : 1'b1;
  assign wr_data     = pass_thru ? sel_data : fill_word;
  assign video_ready = wr_ready;

  sample_fifo #(
    .W     (`VRC_DATA_W),
    .DEPTH (`VRC_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .wr_valid (wr_valid),
    .wr_ready (wr_ready),
    .wr_data  (wr_data),
    .rd_valid (out_valid),
    .rd_ready (out_ready),
    .rd_data  (out_data)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_PRIMARY_SRC: assert property (@(posedge sys_clk) disable iff (rst)
    input_ok && choice_r == video_ref_pkg::primary_input_choice |-> wr_data == pri_data_s)
    else $error("Primary input not on program path");
  AST_BACKUP_SRC: assert property (@(posedge sys_clk) disable iff (rst)
    input_ok && choice_r == video_ref_pkg::backup_input_choice |-> wr_data == bak_data_s)
    else $error("Backup input not on program path");
  AST_AUTO_STD: assert property (@(posedge sys_clk) disable iff (rst)
    std_mode_r == video_ref_pkg::std_auto |=> std_625_r == $past(det_625_s))
    else $error("Auto standard does not follow detector");
  AST_FORCE_525: assert property (@(posedge sys_clk) disable iff (rst)
    std_mode_r == video_ref_pkg::std_525 && det_625_s |=> !input_ok_r)
    else $error("625 accepted while forced to 525");
  AST_FORCE_625: assert property (@(posedge sys_clk) disable iff (rst)
    std_mode_r == video_ref_pkg::std_625 && !det_625_s |=> !input_ok_r)
    else $error("525 accepted while forced to 625");
  AST_LOSS_BLACK: assert property (@(posedge sys_clk) disable iff (rst)
    !input_ok && loss_r == video_ref_pkg::loss_black
    |-> wr_valid && wr_data == (h_pos[0] ? `VRC_BLACK_Y : `VRC_BLACK_C))
    else $error("Black fill missing on input loss");
  AST_LOSS_BLUE: assert property (@(posedge sys_clk) disable iff (rst)
    !input_ok && loss_r == video_ref_pkg::loss_blue && h_pos[1:0] == 2'h0
    |-> wr_data == `VRC_BLUE_CB)
    else $error("Blue fill missing on input loss");
  AST_LOSS_PASS: assert property (@(posedge sys_clk) disable iff (rst)
    loss_r == video_ref_pkg::loss_pass |-> wr_valid == sel_valid && wr_data == sel_data)
    else $error("Pass mode does not forward input");
  AST_LOCK_EXT: assert property (@(posedge sys_clk) disable iff (rst)
    ref_choice_r == video_ref_pkg::ref_external && ext_ok
    |=> lock_src_r == video_ref_pkg::lock_ext)
    else $error("Good external reference not used");
  AST_EXT_FALLBACK: assert property (@(posedge sys_clk) disable iff (rst)
    ref_choice_r == video_ref_pkg::ref_external && !ext_ok && input_ok
    |=> lock_src_r == video_ref_pkg::lock_input)
    else $error("No fallback to program input");
  AST_LOCK_VIDEO: assert property (@(posedge sys_clk) disable iff (rst)
    ref_choice_r == video_ref_pkg::ref_video && input_ok
    |=> lock_src_r == video_ref_pkg::lock_input)
    else $error("Video reference choice not locked to input");
  AST_FREE_RUN: assert property (@(posedge sys_clk) disable iff (rst)
    !input_ok && !(ref_choice_r == video_ref_pkg::ref_external && ext_ok)
    |=> lock_src_r == video_ref_pkg::lock_free && !lock_pulse)
    else $error("Timing not free running without input");
  AST_PHASE_RANGE: assert property (@(posedge sys_clk) disable iff (rst)
    $stable(is_625) |-> h_phase_r <= h_total && v_phase_r <= v_total)
    else $error("Phase offset beyond raster size");
  AST_FACTORY: assert property (@(posedge sys_clk)
    $past(rst) && !rst |-> std_mode_r == video_ref_pkg::std_auto
      && loss_r == video_ref_pkg::loss_black
      && ref_choice_r == video_ref_pkg::ref_external
      && h_phase_r == 12'h000 && v_phase_r == 10'h000)
    else $error("Settings not at factory values after reset");

endmodule // video_input_reference_control
`default_nettype wire

// *** src_model.sv ***
// Video sources and genlock references facing the block
`timescale 1ns/100ps
`default_nettype none
module src_model (
  // Clock and controls
  input  wire logic       sys_clk,
  input  wire logic [1:0] on,
  input  wire logic [2:0] ref_on,
  input  wire logic [9:0] word,
  input  wire logic       rstd,
  // Pins
  output logic [9:0]      pri_data,
  output logic [9:0]      bak_data,
  output logic [1:0]      pres,
  output logic            fsync,
  output logic [2:0]      rsync,
  output logic [2:0]      rs625
);
  logic [5:0] cnt = 6'h00;
  always_ff @(posedge sys_clk) cnt <= cnt + 6'h01;
  // Frames share the reference count, so video stays locked
  assign fsync = (on != 2'h0) && cnt[5];
  assign rsync = ref_on & {3{cnt[5]}};
  assign rs625 = {3{rstd}};
  // Absent inputs show a pattern that changes every cycle
  assign pri_data = on[0] ? word : {4'h0, cnt};
  assign bak_data = on[1] ? ~word : {4'h5, cnt};
  assign pres = on;
endmodule // src_model
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the video input and reference control
`timescale 1ns/100ps
`default_nettype none
`include "video_ref_cfg.svh"
module tb;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic                         sys_clk = 1'b0;
  logic                         rst = 1'b1;
  logic                         cfg_load = 1'b0;
  video_ref_pkg::input_choice_e ic = video_ref_pkg::primary_input_choice;
  video_ref_pkg::std_mode_e     sm = video_ref_pkg::std_auto;
  video_ref_pkg::loss_act_e     la = video_ref_pkg::loss_black;
  video_ref_pkg::ref_choice_e   rc = video_ref_pkg::ref_external;
  video_ref_pkg::ext_ref_e      er = video_ref_pkg::card_reference_connector_choice;
  video_ref_pkg::lock_src_e     lock_src_r;
  logic [11:0]                  hp = 12'h000;
  logic [9:0]                   vp = 10'h000;
  logic [1:0]                   on = 2'h0;
  logic [2:0]                   ref_on = 3'h0;
  logic [9:0]                   word = 10'h300;
  logic                         s625 = 1'b0;
  logic                         rstd = 1'b0;
  logic                         dvalid = 1'b0;
  logic [9:0]                   pri_data, bak_data, out_data, v_phase_r, v_pos;
  logic [11:0]                  h_phase_r, h_pos;
  logic [2:0]                   rsync, rs625;
  logic [1:0]                   pres;
  logic                         fsync, video_ready, out_valid, std_625_r;
  logic                         input_ok_r, frame_start;
  int                           err_total = 0;
  int                           tests_run = 0;
  int                           cyc = 0;
  int                           fs_cnt = 0;

  src_model i_src_model (.sys_clk(sys_clk), .on(on), .ref_on(ref_on), .word(word),
    .rstd(rstd), .pri_data(pri_data), .bak_data(bak_data), .pres(pres),
    .fsync(fsync), .rsync(rsync), .rs625(rs625));

  video_input_reference_control i_video_input_reference_control (
    .sys_clk(sys_clk), .rst(rst), .pri_data(pri_data), .pri_valid(1'b1),
    .pri_present(pres[0]), .bak_data(bak_data), .bak_valid(1'b1),
    .bak_present(pres[1]), .video_ready(video_ready), .det_std_625(s625),
    .det_std_valid(dvalid), .in_frame_sync(fsync), .ref_present(ref_on),
    .ref_std_625(rs625), .ref_sync(rsync), .cfg_load(cfg_load),
    .cfg_input_choice(ic), .cfg_std_mode(sm), .cfg_input_loss_action(la),
    .cfg_ref_choice(rc), .cfg_ext_ref(er), .cfg_h_phase(hp), .cfg_v_phase(vp),
    .out_data(out_data), .out_valid(out_valid), .out_ready(1'b1),
    .lock_src_r(lock_src_r), .std_625_r(std_625_r), .input_ok_r(input_ok_r),
    .h_phase_r(h_phase_r), .v_phase_r(v_phase_r), .h_pos(h_pos), .v_pos(v_pos),
    .frame_start(frame_start));

  // ----------------------------------------
  // Checks and reference model
  // ----------------------------------------
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic load(input int n);
    @(negedge sys_clk) cfg_load = 1'b1;
    @(negedge sys_clk) cfg_load = 1'b0;
    repeat (n) @(negedge sys_clk);
  endtask

  function automatic logic [11:0] exp_lock();
    if (rc == video_ref_pkg::ref_external && ref_on[er] && rstd == s625) return 12'h000;
    return on[ic] ? 12'h001 : 12'h002;
  endfunction

  function automatic logic [11:0] clamp(input int v, input int tot);
    return (v > tot) ? 12'(tot) : 12'(v);
  endfunction

  // Fill sequence phase is not modelled, only the allowed words
  task automatic chk_fill();
    logic [9:0] e;
    case (la)
      video_ref_pkg::loss_black: e = (out_data === 10'h040) ? 10'h040 : 10'h200;
      video_ref_pkg::loss_blue: e = (out_data === 10'h3C0 || out_data === 10'h1D8) ?
                                    out_data : 10'h0A4;
      default: e = {4'h0, out_data[5:0]};
    endcase
    chk(12'(out_data), 12'(e));
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      close_out();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(82));
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    chk(h_phase_r, 12'h000);
    chk(12'(v_phase_r), 12'h000);
    repeat (40) @(negedge sys_clk);
    chk(12'(lock_src_r), exp_lock());
    chk_fill();
    word = 10'h300 | 10'($urandom_range(63, 0));
    on = 2'h1;
    dvalid = 1'b1;
    repeat (40) @(negedge sys_clk);
    chk(12'(out_data), 12'(word));
    chk(12'(out_valid), 12'h001);
    chk(12'(video_ready), 12'h001);
    chk(12'(std_625_r), 12'h000);
    chk(12'(lock_src_r), exp_lock());
    ic = video_ref_pkg::backup_input_choice;
    on = 2'h3;
    load(40);
    chk(12'(out_data), {2'h0, ~word});
    for (int i = 0; i < 3; i++) begin
      er = video_ref_pkg::ext_ref_e'(i);
      ref_on = 3'(1 << i);
      load(8);
      chk(12'(lock_src_r), exp_lock());
    end
    rstd = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk(12'(lock_src_r), exp_lock());
    rstd = 1'b0;
    rc = video_ref_pkg::ref_video;
    load(8);
    chk(12'(lock_src_r), exp_lock());
    on = 2'h0;
    ic = video_ref_pkg::primary_input_choice;
    load(8);
    chk(12'(lock_src_r), exp_lock());
    for (int i = 0; i < 3; i++) begin
      la = video_ref_pkg::loss_act_e'(i);
      load(40);
      repeat (4) @(negedge sys_clk) chk_fill();
    end
    hp = 12'($urandom_range(4095, 0));
    vp = 10'($urandom_range(1023, 0));
    load(4);
    chk(h_phase_r, clamp(hp, `VRC_SPL_525));
    chk(12'(v_phase_r), clamp(vp, `VRC_LPF_525));
    s625 = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk(h_phase_r, clamp(hp, `VRC_SPL_625));
    chk(12'(v_phase_r), clamp(vp, `VRC_LPF_625));
    chk(12'(std_625_r), 12'h001);
    on = 2'h1;
    sm = video_ref_pkg::std_525;
    load(8);
    chk(12'(input_ok_r), 12'h000);
    sm = video_ref_pkg::std_625;
    load(8);
    chk(12'(input_ok_r), 12'h001);
    // One sample and one line of offset: each reference mark starts a frame
    hp = 12'h001;
    vp = 10'h001;
    load(72);
    fs_cnt = 0;
    repeat (128) @(negedge sys_clk) fs_cnt += int'(frame_start);
    chk(12'(fs_cnt), 12'h002);
    close_out();
  end
endmodule // tb
`default_nettype wire
